/* File: inc/cic_pkg.sv */
// Package with register map, field positions, reset values and command codes
`default_nettype none
package cic_pkg;
    localparam int CIC_AW = 6;
    localparam logic [5:0] CIC_ADDR_RSVD = 6'h00;
    localparam logic [5:0] CIC_ADDR_CMD = 6'h01;
    localparam logic [5:0] CIC_ADDR_MIEN = 6'h02;
    localparam logic [5:0] CIC_ADDR_SIEN = 6'h03;
    localparam logic [5:0] CIC_ADDR_MFLG = 6'h04;
    localparam logic [5:0] CIC_ADDR_SFLG = 6'h05;
    localparam logic [7:0] CIC_RST_RSVD = 8'h00;
    localparam logic [7:0] CIC_RST_CMD = 8'h20;
    localparam logic [7:0] CIC_RST_MIEN = 8'h80;
    localparam logic [7:0] CIC_RST_SIEN = 8'h00;
    localparam logic [7:0] CIC_RST_MFLG = 8'h14;
    localparam logic [7:0] CIC_RST_SFLG = 8'h00;
    localparam int CIC_BIT_RXOFF = 5;
    localparam int CIC_BIT_SLEEP = 4;
    localparam int CIC_BIT_TOP = 7;
    localparam int CIC_BIT_AUX = 4;
    localparam int CIC_BIT_CRC = 2;
    localparam int CIC_BIT_IDLE = 4;
    localparam logic [7:0] CIC_SFLG_MASK = 8'h14;
    localparam logic [3:0] CIC_CMD_IDLE = 4'h0;
    localparam logic [3:0] CIC_CMD_SOFTRST = 4'hf;
    localparam logic [15:0] CIC_CMD_KNOWN = 16'hb3af;
    localparam int CIC_WAKE_CYCLES = 16;
    localparam int CIC_RESET_CYCLES = 8;
endpackage : cic_pkg
`default_nettype wire

/* File: inc/cic_flag_if.sv */
// Interface carrying flag state between the top and the flag register module
`timescale 1ns/1ps
`default_nettype none
interface cic_flag_if;
    logic [6:0] hw_set;
    logic wr_en;
    logic [7:0] wr_data;
    logic [6:0] flags;
    modport owner (input hw_set, input wr_en, input wr_data, output flags);
    modport user (output hw_set, output wr_en, output wr_data, input flags);
endinterface : cic_flag_if
`default_nettype wire

/* File: hw/cic_flag_reg.sv */
// Set/clear flag register with hardware set winning over software clear
`timescale 1ns/1ps
`default_nettype none
module cic_flag_reg #(
    parameter logic [6:0] RESET_VALUE = 7'h00,
    parameter logic [6:0] USED_MASK = 7'h7f
) (
    input wire logic clock,
    input wire logic rst_n,
    cic_flag_if.owner fl
);
    import cic_pkg::*;
    logic [6:0] flag_reg;
    logic [6:0] flag_next;
    always_comb begin
        flag_next = flag_reg;
        if (fl.wr_en) begin
            if (fl.wr_data[CIC_BIT_TOP]) begin
                flag_next = flag_reg | fl.wr_data[6:0]; // R14
            end else begin
                flag_next = flag_reg & ~fl.wr_data[6:0]; // R14
            end
        end
        flag_next = (flag_next | fl.hw_set) & USED_MASK;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= RESET_VALUE;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign fl.flags = flag_reg;
    chk_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (fl.hw_set & USED_MASK) != 7'h00 |=> (flag_reg & $past(fl.hw_set & USED_MASK)) == $past(fl.hw_set & USED_MASK))
        else $error("hardware flag set lost"); // R14
    chk_clear_takes: assert property (@(posedge clock) disable iff (!rst_n)
        fl.wr_en && !fl.wr_data[CIC_BIT_TOP] && fl.hw_set == 7'h00
        |=> (flag_reg & $past(fl.wr_data[6:0])) == 7'h00)
        else $error("flag clear not applied"); // R14
endmodule : cic_flag_reg
`default_nettype wire

/* File: hw/cic_top.sv */
// Command, interrupt enable and flag registers with interrupt pin control
// What this block does
// R01 - Address zero is reserved, resets to zero, does nothing.
// R02 - Command register resets to 20h; bit 5 powers receiver analog off.
// R03 - Writing one to bit 4 enters software power-down.
// R04 - Writing zero starts wake-up; bit reads one until ready.
// R05 - Power-down cannot be set while software reset command runs.
// R06 - Low command bits start a command; reads show running command.
// R07 - Main enable resets 80h; bit 7 inverts the interrupt pin.
// R08 - Inversion clear passes status directly; defaults leave pin undriven.
// R09 - Main enable bits 6..0 gate the seven main request flags.
// R10 - Secondary enable resets 00h; bit 7 selects push-pull or open-drain.
// R11 - Secondary bit 4 gates the aux input activity request.
// R12 - Secondary bit 2 gates the checksum done request.
// R13 - Main flag register resets 14h; bit 7 write-only, rest hardware flags.
// R14 - Flag writes set marked bits if bit 7 one, else clear them.
// R15 - Unknown command returns to idle and raises idle flag; host idle doesn't.
// R16 - Summary is OR of enabled flags, then polarity and drive applied.
`timescale 1ns/1ps
`default_nettype none
module cic_top #(
    parameter int WAKE_CYCLES = cic_pkg::CIC_WAKE_CYCLES,
    parameter int RESET_CYCLES = cic_pkg::CIC_RESET_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [cic_pkg::CIC_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] main_events,
    input wire logic aux_modulation_input,
    input wire logic checksum_done_event,
    input wire logic command_done,
    output logic receiver_analog_off,
    output logic soft_sleep,
    output logic [3:0] active_command,
    output logic command_start,
    output logic irq_out,
    output logic irq_oe,
    output logic irq_status
);
    import cic_pkg::*;
    typedef enum logic [1:0] {CIC_RUN, CIC_SLEEP, CIC_WAKE} cic_pwr_t;
    function automatic logic cmd_known(input logic [3:0] code);
        cmd_known = CIC_CMD_KNOWN[code];
    endfunction : cmd_known
    cic_pwr_t pwr_reg, pwr_next;
    logic rxoff_reg, rxoff_next;
    logic [3:0] cmd_reg, cmd_next;
    logic [7:0] mien_reg, mien_next;
    logic [7:0] sien_reg, sien_next;
    logic [15:0] cnt_reg, cnt_next;
    logic start_reg, start_next;
    logic idle_set;
    logic aux_prev_reg;
    logic aux_armed_reg;
    logic sleep_reg, sleep_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next, oe_reg, oe_next, stat_reg, stat_next;
    logic wr_cmd, wr_mien, wr_sien;
    cic_flag_if mf();
    cic_flag_if sf();
    cic_flag_reg #(.RESET_VALUE(CIC_RST_MFLG[6:0]), .USED_MASK(7'h7f)) u_main (
        .clock(clock), .rst_n(rst_n), .fl(mf)); // R13
    cic_flag_reg #(.RESET_VALUE(CIC_RST_SFLG[6:0]), .USED_MASK(CIC_SFLG_MASK[6:0])) u_sec (
        .clock(clock), .rst_n(rst_n), .fl(sf));
    assign wr_cmd = reg_wr && reg_addr == CIC_ADDR_CMD;
    assign wr_mien = reg_wr && reg_addr == CIC_ADDR_MIEN;
    assign wr_sien = reg_wr && reg_addr == CIC_ADDR_SIEN;
    assign mf.wr_en = reg_wr && reg_addr == CIC_ADDR_MFLG; // R14
    assign mf.wr_data = reg_wdata;
    assign sf.wr_en = reg_wr && reg_addr == CIC_ADDR_SFLG;
    assign sf.wr_data = reg_wdata;
    assign mf.hw_set = main_events | {2'b00, idle_set, 4'h0}; // R15
    always_comb begin
        sf.hw_set = 7'h00;
        // No edge is reported until the previous input level has been seen once
        sf.hw_set[CIC_BIT_AUX] = aux_armed_reg & (aux_modulation_input ^ aux_prev_reg); // R11
        sf.hw_set[CIC_BIT_CRC] = checksum_done_event;
    end
    // Command and power state
    always_comb begin
        pwr_next = pwr_reg;
        rxoff_next = rxoff_reg;
        cmd_next = cmd_reg;
        cnt_next = cnt_reg;
        start_next = 1'b0;
        idle_set = 1'b0;
        if (cmd_reg == CIC_CMD_SOFTRST) begin
            if (cnt_reg == 16'h0000) begin
                cmd_next = CIC_CMD_IDLE;
                idle_set = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (cmd_reg != CIC_CMD_IDLE && command_done) begin
            cmd_next = CIC_CMD_IDLE;
            idle_set = 1'b1;
        end
        if (pwr_reg == CIC_WAKE) begin
            if (cnt_reg == 16'h0000) begin
                pwr_next = CIC_RUN; // R04
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end
        if (wr_cmd) begin
            rxoff_next = reg_wdata[CIC_BIT_RXOFF]; // R02
            if (reg_wdata[CIC_BIT_SLEEP] && cmd_reg != CIC_CMD_SOFTRST) begin
                pwr_next = CIC_SLEEP; // R03 R05
            end else if (!reg_wdata[CIC_BIT_SLEEP] && pwr_reg == CIC_SLEEP) begin
                pwr_next = CIC_WAKE; // R04
                cnt_next = 16'(WAKE_CYCLES - 1);
            end
            if (cmd_known(reg_wdata[3:0])) begin
                cmd_next = reg_wdata[3:0]; // R06
                idle_set = 1'b0; // R15
                start_next = reg_wdata[3:0] != CIC_CMD_IDLE;
                if (reg_wdata[3:0] == CIC_CMD_SOFTRST) begin
                    cnt_next = 16'(RESET_CYCLES - 1);
                end
            end else begin
                cmd_next = CIC_CMD_IDLE; // R15
                idle_set = 1'b1; // R15
            end
        end
        sleep_next = pwr_next == CIC_SLEEP; // R03
    end
    // Read mux and interrupt pin
    always_comb begin
        rdata_next = 8'h00; // R01
        if (reg_rd) begin
            case (reg_addr)
                CIC_ADDR_CMD: rdata_next = {2'b00, rxoff_reg, pwr_reg != CIC_RUN, cmd_reg}; // R04 R06
                CIC_ADDR_MIEN: rdata_next = mien_reg;
                CIC_ADDR_SIEN: rdata_next = sien_reg & (CIC_SFLG_MASK | 8'h80);
                CIC_ADDR_MFLG: rdata_next = {1'b0, mf.flags}; // R13
                CIC_ADDR_SFLG: rdata_next = {1'b0, sf.flags};
                default: rdata_next = 8'h00;
            endcase
        end
        mien_next = wr_mien ? reg_wdata : mien_reg;
        sien_next = wr_sien ? reg_wdata : sien_reg;
        stat_next = |(mf.flags & mien_reg[6:0]) | |(sf.flags & sien_reg[6:0]); // R09 R11 R12 R16
        irq_next = stat_next ^ mien_reg[CIC_BIT_TOP]; // R07 R08
        oe_next = sien_reg[CIC_BIT_TOP] | ~irq_next; // R10 R08
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= CIC_RUN;
            rxoff_reg <= CIC_RST_CMD[CIC_BIT_RXOFF];
            cmd_reg <= CIC_RST_CMD[3:0];
            cnt_reg <= 16'h0000;
            start_reg <= 1'b0;
            mien_reg <= CIC_RST_MIEN;
            sien_reg <= CIC_RST_SIEN;
            aux_prev_reg <= 1'b0;
            aux_armed_reg <= 1'b0;
            sleep_reg <= 1'b0;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            oe_reg <= 1'b0;
            stat_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            rxoff_reg <= rxoff_next;
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
            start_reg <= start_next;
            mien_reg <= mien_next;
            sien_reg <= sien_next;
            aux_prev_reg <= aux_modulation_input;
            aux_armed_reg <= 1'b1;
            sleep_reg <= sleep_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            oe_reg <= oe_next;
            stat_reg <= stat_next;
        end
    end
    assign reg_rdata = rdata_reg;
    assign receiver_analog_off = rxoff_reg;
    assign soft_sleep = sleep_reg;
    assign active_command = cmd_reg;
    assign command_start = start_reg;
    assign irq_out = irq_reg;
    assign irq_oe = oe_reg;
    assign irq_status = stat_reg;
    chk_sleep_blocked: assert property (@(posedge clock) disable iff (!rst_n)
        wr_cmd && reg_wdata[CIC_BIT_SLEEP] && cmd_reg == CIC_CMD_SOFTRST && pwr_reg == CIC_RUN
        |=> pwr_reg == CIC_RUN)
        else $error("power-down set during soft reset"); // R05
    chk_sleep_enter: assert property (@(posedge clock) disable iff (!rst_n)
        wr_cmd && reg_wdata[CIC_BIT_SLEEP] && cmd_reg != CIC_CMD_SOFTRST |=> soft_sleep)
        else $error("power-down not entered"); // R03
    chk_wake_reads_one: assert property (@(posedge clock) disable iff (!rst_n)
        wr_cmd && !reg_wdata[CIC_BIT_SLEEP] && pwr_reg == CIC_SLEEP |=> pwr_reg == CIC_WAKE ##1 pwr_reg != CIC_RUN)
        else $error("wake-up not held"); // R04
    chk_unknown_idle: assert property (@(posedge clock) disable iff (!rst_n)
        wr_cmd && !cmd_known(reg_wdata[3:0]) |=> cmd_reg == CIC_CMD_IDLE && mf.flags[CIC_BIT_IDLE])
        else $error("unknown command not idled"); // R15
    chk_irq_polarity: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> irq_out == (irq_status ^ $past(mien_reg[CIC_BIT_TOP])))
        else $error("irq pin polarity wrong"); // R07
    chk_rxoff_follow: assert property (@(posedge clock) disable iff (!rst_n)
        wr_cmd |=> receiver_analog_off == $past(reg_wdata[CIC_BIT_RXOFF]))
        else $error("receiver off not written"); // R02
    chk_drive_mode: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> irq_oe == ($past(sien_reg[CIC_BIT_TOP]) || !irq_out))
        else $error("open-drain drove high"); // R10
    chk_summary: assert property (@(posedge clock) disable iff (!rst_n)
        (mf.flags & mien_reg[6:0]) != 7'h00 |=> irq_status)
        else $error("enabled flag missing from summary"); // R16
endmodule : cic_top
`default_nettype wire

/* File: tb/cic_host_model.sv */
// Host model issuing single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module cic_host_model (
    input wire logic clock,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [cic_pkg::CIC_AW-1:0] reg_addr = '0,
    output logic [7:0] reg_wdata = 8'h00,
    input wire logic [7:0] reg_rdata
);
    task automatic acc(input logic w, input logic [cic_pkg::CIC_AW-1:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clock);
        #1;
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask : acc
endmodule : cic_host_model
`default_nettype wire

/* File: tb/cic_top_bench.sv */
// Self-checking bench for the command and interrupt control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module cic_top_bench;
    import cic_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, aux_modulation_input = 1'b0, checksum_done_event = 1'b0, command_done = 1'b0;
    logic reg_wr, reg_rd, receiver_analog_off, soft_sleep, command_start, irq_out, irq_oe, irq_status, irq_pin;
    logic [CIC_AW-1:0] reg_addr;
    logic [6:0] main_events = 7'h00;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [3:0] active_command;
    int num_errors = 0, samples_checked = 0;
    cic_top #(.WAKE_CYCLES(8)) i_cic_top (
        .clock(clock),
        .rst_n(rst_n),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .main_events(main_events),
        .aux_modulation_input(aux_modulation_input),
        .checksum_done_event(checksum_done_event),
        .command_done(command_done),
        .receiver_analog_off(receiver_analog_off),
        .soft_sleep(soft_sleep),
        .active_command(active_command),
        .command_start(command_start),
        .irq_out(irq_out),
        .irq_oe(irq_oe),
        .irq_status(irq_status)
    );
    cic_host_model i_cic_host_model (
        .clock(clock),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );
    assign irq_pin = irq_oe ? irq_out : 1'b1;
    initial forever #50 clock = ~clock;
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic wr(input logic [CIC_AW-1:0] a, input logic [7:0] d);
        i_cic_host_model.acc(1'b1, a, d, rv);
    endtask : wr
    task automatic rchk(input logic [CIC_AW-1:0] a, input logic [7:0] e);
        i_cic_host_model.acc(1'b0, a, 8'h00, rv);
        `CHK(rv, e)
    endtask : rchk
    task automatic pin(input logic [7:0] m, input logic [3:0] e);
        {checksum_done_event, main_events} = m;
        step(1);
        {checksum_done_event, main_events} = 8'h00;
        step(3);
        `CHK({irq_status, irq_out, irq_oe, irq_pin}, e)
    endtask : pin
    task automatic end_sim();
        $display("Checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic t_reset_power();
        pin(8'h00, 4'b0101);
        `CHK(receiver_analog_off, 1'b1)
        rchk(CIC_ADDR_CMD, 8'h20);
        rchk(CIC_ADDR_MIEN, 8'h80);
        rchk(CIC_ADDR_SIEN, 8'h00);
        rchk(CIC_ADDR_MFLG, 8'h14);
        wr(CIC_ADDR_RSVD, 8'hff);
        rchk(CIC_ADDR_RSVD, 8'h00);
        wr(CIC_ADDR_CMD, 8'h10);
        `CHK({soft_sleep, receiver_analog_off}, 2'b10)
        wr(CIC_ADDR_CMD, 8'h20);
        rchk(CIC_ADDR_CMD, 8'h30);
        step(10);
        rchk(CIC_ADDR_CMD, 8'h20);
        wr(CIC_ADDR_CMD, 8'h2f);
        wr(CIC_ADDR_CMD, 8'h3f);
        `CHK({soft_sleep, active_command}, 5'h0f)
        step(12);
        rchk(CIC_ADDR_CMD, 8'h20);
    endtask : t_reset_power
    task automatic t_command();
        wr(CIC_ADDR_CMD, 8'h23);
        `CHK({command_start, active_command}, 5'h13)
        command_done = 1'b1;
        step(1);
        command_done = 1'b0;
        rchk(CIC_ADDR_CMD, 8'h20);
        wr(CIC_ADDR_MFLG, 8'h7f);
        wr(CIC_ADDR_CMD, 8'h24);
        rchk(CIC_ADDR_MFLG, 8'h10);
        wr(CIC_ADDR_MFLG, 8'h85);
        rchk(CIC_ADDR_MFLG, 8'h15);
        wr(CIC_ADDR_MFLG, 8'h7f);
        wr(CIC_ADDR_CMD, 8'h23);
        wr(CIC_ADDR_CMD, 8'h20);
        `CHK({command_start, active_command}, 5'h00)
        rchk(CIC_ADDR_MFLG, 8'h00);
    endtask : t_command
    task automatic t_irq();
        wr(CIC_ADDR_SIEN, 8'h80);
        for (int i = 0; i < 7; i++) begin
            wr(CIC_ADDR_MFLG, 8'h7f);
            wr(CIC_ADDR_MIEN, 8'(1 << i));
            pin(8'(1 << ((i + 1) % 7)), 4'b0010);
            pin(8'(1 << i), 4'b1111);
        end
        rchk(CIC_ADDR_MFLG, 8'h41);
        wr(CIC_ADDR_MIEN, 8'hc0);
        pin(8'h00, 4'b1010);
        wr(CIC_ADDR_SIEN, 8'h00);
        pin(8'h00, 4'b1010);
        wr(CIC_ADDR_MFLG, 8'h7f);
        pin(8'h00, 4'b0101);
        wr(CIC_ADDR_MIEN, 8'h00);
        wr(CIC_ADDR_SIEN, 8'h90);
        wr(CIC_ADDR_SFLG, 8'h14);
        aux_modulation_input = 1'b1;
        pin(8'h00, 4'b1111);
        wr(CIC_ADDR_SIEN, 8'h84);
        pin(8'h00, 4'b0010);
        pin(8'h80, 4'b1111);
    endtask : t_irq
    initial begin
        step(2);
        rst_n = 1'b1;
        t_reset_power();
        t_command();
        t_irq();
        end_sim();
    end
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
endmodule : cic_top_bench
`default_nettype wire
